/* ufs_dev.sv */
// front end serial port, register map and operating-state sequencer
`timescale 1ns/1ps
`include "ufs_map.svh"
module ufs_dev #(
    parameter int WAIT_CYC = `UFS_WAIT_CYC
) (
    input  wire logic              clk,
    input  wire logic              rst,
    ufs_if.dev                     lnk,
    input  wire logic              drive_supply_ready,
    input  wire logic              burst_end,
    input  wire logic              pulse_count_fault,
    input  wire logic              drive_stuck_fault,
    input  wire logic              nvm_crc_fault,
    output ufs_pkg::ufs_state_t    operating_state_code,
    output logic                   bandpass_bypass,
    output logic [1:0]             hp_corner_sel,
    output logic [5:0]             center_freq_code,
    output logic                   factory_trim_used,
    output logic [1:0]             q_factor_select
);
    import ufs_pkg::*;

    logic [7:0]  regs_r [0:15];
    logic [2:0]  sclk_s, ncs_s;
    logic [1:0]  sdi_s;
    logic [4:0]  cnt_r;
    logic [15:0] rx_r, tx_r;
    logic        perr_r, sdo_oe_r;
    ufs_state_t  st_r, st_nxt;
    logic        pwr_ok_r, ready_r;
    logic [31:0] wait_r;
    logic [6:0]  hdr_r;
    logic        burst_q_r;

    function automatic logic odd_ok(input logic [15:0] f);
        odd_ok = ^f;
    endfunction

    // edge detect works on the second and third sync stages only
    wire sclk_rise = sclk_s[1] & ~sclk_s[2];
    wire sclk_fall = ~sclk_s[1] & sclk_s[2];
    wire ncs_high  = ncs_s[1];
    wire ncs_rise  = ncs_s[1] & ~ncs_s[2];
    wire [15:0] rx_full = rx_r;
    wire        rx_wr   = rx_full[`UFS_F_RW];
    wire [5:0]  rx_addr = rx_full[14:9];
    wire        rx_good = odd_ok(rx_full);
    wire        in_map  = rx_addr >= `UFS_A_BPF_A && rx_addr <= `UFS_A_REVID;
    wire [3:0]  ridx    = rx_full[12:9];
    // with seven bits in, rx_r[6] is the rw bit and rx_r[5:0] the address
    wire [3:0]  hidx    = rx_r[3:0];
    wire [5:0]  status  = {ready_r, pulse_count_fault, drive_stuck_fault,
                           nvm_crc_fault, st_r};
    wire [7:0]  mode_r  = regs_r[5];
    // a level would re-enter burst right after every burst end
    wire        burst_evt = mode_r[`UFS_F_BURST] & ~burst_q_r;
    wire [7:0]  rd_val  = (hidx == 4'hc) ? {4'h0, status[5:2]} :
                          (hidx == 4'hd) ? `UFS_DEVID_VAL :
                          (hidx == 4'he) ? `UFS_REVID_VAL : regs_r[hidx];
    wire [6:0]  tx_hi   = {perr_r, status};
    wire [7:0]  tx_lo   = !rx_r[6] ? {2'b00, rx_r[5:0]} : rd_val;

    // two-flop synchronisers on link pins
    always_ff @(posedge clk) begin
        if (rst) begin
            sclk_s <= 3'b000;
            ncs_s  <= 3'b111;
            sdi_s  <= 2'b00;
        end else begin
            sclk_s <= {sclk_s[1:0], lnk.sclk};
            ncs_s  <= {ncs_s[1:0], lnk.chip_select_n};
            sdi_s  <= {sdi_s[0], lnk.sdi};
        end
    end

    // receive shifter; select high holds it idle
    always_ff @(posedge clk) begin
        if (rst || ncs_high) begin
            cnt_r <= 5'd0;
            rx_r  <= 16'h0000;
        end else if (sclk_fall && cnt_r < 5'd16) begin
            rx_r  <= {rx_r[14:0], sdi_s[1]};
            cnt_r <= cnt_r + 5'd1;
        end
    end

    // transmit shifter: header tracked from select until the first fall, parity and data byte at the eighth rise
    always_ff @(posedge clk) begin
        if (rst || ncs_high) begin
            tx_r     <= 16'h0000;
            hdr_r    <= 7'h00;
            sdo_oe_r <= 1'b0;
        end else begin
            sdo_oe_r <= 1'b1;
            if (cnt_r == 5'd0 && !sclk_rise) begin
                tx_r  <= {tx_hi, ~^{tx_hi, 8'h00}, 8'h00};
                hdr_r <= tx_hi;
            end else if (sclk_rise && cnt_r == 5'd7)
                tx_r <= {~^{hdr_r, tx_lo}, tx_lo, 7'h00};
            else if (sclk_rise && cnt_r != 5'd0)
                tx_r <= {tx_r[14:0], 1'b0};
        end
    end
    assign lnk.sdo_o  = tx_r[15];
    assign lnk.sdo_oe = sdo_oe_r;

    // frame commit at select release; odd parity guards writes
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 16; i++)
                regs_r[i] <= 8'h00;
            regs_r[6] <= `UFS_RST_DRV_REG;
            perr_r    <= 1'b0;
        end else if (ncs_rise && cnt_r == 5'd16) begin
            perr_r <= ~rx_good;
            if (rx_good && !rx_wr && in_map && ridx < 4'hc)
                regs_r[ridx] <= (ridx == 4'h1) ? {2'b00, rx_r[5:0]} : rx_r[7:0];
        end
    end

    // power gate: supply ready, timeout, or regulation off
    always_ff @(posedge clk) begin
        if (rst || mode_r[`UFS_F_SLEEP]) begin
            wait_r   <= 32'd0;
            pwr_ok_r <= 1'b0;
        end else if (!pwr_ok_r) begin
            wait_r <= wait_r + 32'd1;
            if (drive_supply_ready || wait_r >= WAIT_CYC - 1 || !mode_r[`UFS_F_REG_EN])
                pwr_ok_r <= 1'b1;
        end
    end

    // operating state selection
    always_comb begin
        st_nxt = st_r;
        if (mode_r[`UFS_F_SLEEP])
            st_nxt = UFS_SLEEP;
        else if (!pwr_ok_r)
            st_nxt = st_r;
        else if (mode_r[`UFS_F_STDBY])
            st_nxt = UFS_STANDBY;
        else if (st_r == UFS_BURST)
            st_nxt = burst_end ? UFS_LISTEN : UFS_BURST;
        else if (burst_evt)
            st_nxt = UFS_BURST;
        else
            st_nxt = UFS_LISTEN;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r      <= UFS_SLEEP;
            ready_r   <= 1'b0;
            burst_q_r <= 1'b0;
        end else begin
            st_r      <= st_nxt;
            ready_r   <= drive_supply_ready;
            burst_q_r <= mode_r[`UFS_F_BURST];
        end
    end

    // filter decode, registered for clean outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            operating_state_code <= UFS_SLEEP;
            bandpass_bypass      <= 1'b0;
            hp_corner_sel        <= 2'b00;
            center_freq_code     <= 6'h00;
            factory_trim_used    <= 1'b1;
            q_factor_select      <= 2'b00;
        end else begin
            operating_state_code <= st_r;
            bandpass_bypass      <= regs_r[0][`UFS_F_BYPASS];
            hp_corner_sel        <= regs_r[0][5:4];
            center_freq_code     <= (regs_r[0][`UFS_F_TRIMOVR] && !regs_r[0][`UFS_F_BYPASS]) ?
                                    regs_r[0][5:0] + {2'b00, regs_r[1][3:0]} : regs_r[0][5:0];
            factory_trim_used    <= !(regs_r[0][`UFS_F_TRIMOVR] && !regs_r[0][`UFS_F_BYPASS]);
            q_factor_select      <= regs_r[1][5:4];
        end
    end
endmodule

/* ufs_map.svh */
// register offsets, field positions, reset values and timing counts
`ifndef UFS_MAP_SVH
`define UFS_MAP_SVH
`define UFS_A_BPF_A      6'h10
`define UFS_A_BPF_B      6'h11
`define UFS_A_LOG_A      6'h12
`define UFS_A_LOG_B      6'h13
`define UFS_A_DEV        6'h14
`define UFS_A_DRV_REG    6'h16
`define UFS_A_ECHO       6'h17
`define UFS_A_ZC         6'h18
`define UFS_A_XFMR       6'h19
`define UFS_A_BURST      6'h1a
`define UFS_A_TOF        6'h1b
`define UFS_A_FAULT      6'h1c
`define UFS_A_DEVID      6'h1d
`define UFS_A_REVID      6'h1e
`define UFS_A_MODE       6'h15
`define UFS_F_RW         15
`define UFS_F_PAR        8
`define UFS_F_BYPASS     6
`define UFS_F_TRIMOVR    7
`define UFS_F_SLEEP      0
`define UFS_F_STDBY      1
`define UFS_F_REG_EN     2
`define UFS_F_BURST      3
`define UFS_RST_DRV_REG  8'h20
`define UFS_DEVID_VAL    8'h5a
`define UFS_REVID_VAL    8'h01
`define UFS_WAIT_MS      64
`define UFS_CLK_KHZ      100000
`define UFS_WAIT_CYC     (`UFS_WAIT_MS * `UFS_CLK_KHZ)
`define UFS_HDIV         6
`define UFS_APB_CTRL     12'h000
`define UFS_APB_WDATA    12'h004
`define UFS_APB_STAT     12'h008
`define UFS_APB_RDATA    12'h00c
`endif

/* ufs_pkg.sv */
// shared types of the serial configuration port
package ufs_pkg;
    typedef enum logic [1:0] {
        UFS_LISTEN  = 2'b00,
        UFS_BURST   = 2'b01,
        UFS_STANDBY = 2'b10,
        UFS_SLEEP   = 2'b11
    } ufs_state_t;
    typedef logic [15:0] ufs_frame_t;
endpackage

/* ufs_if.sv */
// serial link between controller and front end
`timescale 1ns/1ps
interface ufs_if;
    logic sclk;
    logic chip_select_n;
    logic sdi;
    logic sdo_o;
    logic sdo_oe;
    logic sdo;
    assign sdo = sdo_oe ? sdo_o : 1'b1;
    modport dev (input sclk, input chip_select_n, input sdi, output sdo_o, output sdo_oe);
    modport ctl (output sclk, output chip_select_n, output sdi, input sdo);
endinterface

/* ufs_ctl.sv */
// controller end: apb registers drive one serial frame per command
`timescale 1ns/1ps
`include "ufs_map.svh"
module ufs_ctl (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    ufs_if.ctl               lnk
);
    import ufs_pkg::*;

    logic [15:0] cmd_r, sh_r, rsp_r;
    logic        busy_r, go_r, sclk_r, ncs_r;
    logic [2:0]  div_r;
    logic [5:0]  ph_r;
    logic [1:0]  sdo_s;

    wire acc  = psel & penable;
    wire tick = div_r == 3'(`UFS_HDIV - 1);
    wire hit_ctrl  = paddr == `UFS_APB_CTRL;
    wire hit_wdata = paddr == `UFS_APB_WDATA;
    wire hit_stat  = paddr == `UFS_APB_STAT;
    wire hit_rdata = paddr == `UFS_APB_RDATA;
    wire [15:0] pw16 = pwdata[15:0];

    // apb slave, zero wait states
    always_ff @(posedge clk) begin
        if (rst) begin
            cmd_r   <= 16'h0000;
            go_r    <= 1'b0;
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            go_r    <= acc && pwrite && hit_ctrl && pwdata[0] && !busy_r;
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !(hit_ctrl || hit_wdata || hit_stat || hit_rdata);
            if (acc && pwrite && hit_wdata && !busy_r)
                cmd_r <= {pw16[15:9], ~^{pw16[15:9], pw16[7:0]}, pw16[7:0]};
            if (psel && !penable)
                prdata <= hit_stat  ? {31'h0, busy_r | go_r} :
                          hit_rdata ? {16'h0, rsp_r} :
                          hit_wdata ? {16'h0, cmd_r} : 32'h0000_0000;
        end
    end

    // serial engine: clock divider, msb first, select raised after each frame
    always_ff @(posedge clk) begin
        if (rst) begin
            busy_r <= 1'b0;
            div_r  <= 3'd0;
            ph_r   <= 6'd0;
            sclk_r <= 1'b0;
            ncs_r  <= 1'b1;
            sh_r   <= 16'h0000;
            rsp_r  <= 16'h0000;
            sdo_s  <= 2'b00;
        end else begin
            sdo_s <= {sdo_s[0], lnk.sdo};
            div_r <= (tick || !busy_r) ? 3'd0 : div_r + 3'd1;
            if (go_r) begin
                busy_r <= 1'b1;
                ncs_r  <= 1'b0;
                sh_r   <= cmd_r;
                ph_r   <= 6'd0;
            end else if (busy_r && tick) begin
                ph_r <= ph_r + 6'd1;
                if (ph_r < 6'd32) begin
                    sclk_r <= ~ph_r[0];
                    // sdi moves on rises after the first, so bit 15 stands from select
                    if (ph_r[0])
                        rsp_r <= {rsp_r[14:0], sdo_s[1]};
                    else if (ph_r != 6'd0)
                        sh_r  <= {sh_r[14:0], 1'b0};
                end else if (ph_r == 6'd34) begin
                    ncs_r <= 1'b1;
                end else if (ph_r == 6'd40) begin
                    busy_r <= 1'b0;
                end
            end
        end
    end
    assign lnk.sclk          = sclk_r;
    assign lnk.chip_select_n = ncs_r;
    assign lnk.sdi           = sh_r[15];
endmodule

/* ufs_assertions.sv */
// checker for the serial link: framing, edges and parity
`timescale 1ns/1ps
module ufs_assertions (
    input wire logic clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic chip_select_n,
    input wire logic sdi,
    input wire logic sdo_o,
    input wire logic sdo_oe,
    input wire logic sdo
);
    logic        sclk_q_r;
    logic [4:0]  bit_cnt_r;
    logic [15:0] sdi_w_r;
    logic [15:0] sdo_w_r;
    wire         sclk_fall = sclk_q_r & ~sclk;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // both lines are captured on falling sclk, where their receivers sample them
    always_ff @(posedge clk) begin
        sclk_q_r <= sclk;
        if (rst || chip_select_n) begin
            bit_cnt_r <= 5'h0;
        end else if (sclk_fall) begin
            bit_cnt_r <= bit_cnt_r + 5'h1;
            sdi_w_r   <= {sdi_w_r[14:0], sdi};
            sdo_w_r   <= {sdo_w_r[14:0], sdo};
        end
    end
    // deselect is given a short grace for the device's input sync
    sequence idle_s;
        chip_select_n [*4];
    endsequence
    sequence fall_in_frame_s;
        sclk_fall && !chip_select_n;
    endsequence
    sequence frame_end_s;
        $rose(chip_select_n);
    endsequence
    a_out_released: assert property (idle_s |-> !sdo_oe) else $error("sdo driven while deselected");
    a_out_driven: assert property ($fell(chip_select_n) |-> ##[0:6] sdo_oe) else $error("sdo not driven");
    a_sclk_idle: assert property (chip_select_n |-> !sclk) else $error("sclk active while deselected");
    a_sdi_steady: assert property (fall_in_frame_s |-> $stable(sdi)) else $error("sdi moved at sample");
    a_sdo_steady: assert property (fall_in_frame_s |-> $stable(sdo)) else $error("sdo moved at sample");
    a_drive_steady: assert property ((sclk_fall && !chip_select_n && sdo_oe) |-> $stable(sdo_o))
        else $error("driven sdo moved at sample");
    a_frame_length: assert property (frame_end_s |-> bit_cnt_r == 5'h10) else $error("frame not 16 bits");
    a_select_gap: assert property (frame_end_s |=> chip_select_n [*2]) else $error("select gap too short");
    a_cmd_parity: assert property (frame_end_s |-> ^sdi_w_r) else $error("command parity not odd");
    a_resp_parity: assert property (frame_end_s |-> ^sdo_w_r) else $error("response parity not odd");
endmodule

/* ufs_bench.sv */
// bench: apb-driven controller facing the front end over the link
`timescale 1ns/1ps
`include "ufs_map.svh"
module ufs_bench;
    import ufs_pkg::*;
    localparam int WAIT_T = 400;
    logic        clk     = 1'b0;
    logic        rst     = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [4:0]  flt     = 5'h00; // ready, pulse, stuck, crc, burst end
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    ufs_state_t  st;
    logic        byp;
    logic        fac;
    logic [1:0]  cor;
    logic [1:0]  qs;
    logic [5:0]  cf;
    int          n_errors   = 0;
    int          n_compared = 0;
    int          cyc        = 0;
    ufs_if lnk();
    ufs_dev #(.WAIT_CYC(WAIT_T)) i_ufs_dev (.clk(clk), .rst(rst), .lnk(lnk), .drive_supply_ready(flt[4]),
        .burst_end(flt[0]), .pulse_count_fault(flt[3]), .drive_stuck_fault(flt[2]), .nvm_crc_fault(flt[1]),
        .operating_state_code(st), .bandpass_bypass(byp), .hp_corner_sel(cor), .center_freq_code(cf),
        .factory_trim_used(fac), .q_factor_select(qs));
    ufs_ctl i_ufs_ctl (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk));
    ufs_assertions i_ufs_assertions (.clk(clk), .rst(rst), .sclk(lnk.sclk), .chip_select_n(lnk.chip_select_n),
        .sdi(lnk.sdi), .sdo_o(lnk.sdo_o), .sdo_oe(lnk.sdo_oe), .sdo(lnk.sdo));
    // clock and cycle ceiling
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            test_done();
        end
    end
    task chk(input logic [15:0] s, input logic [15:0] e);
        n_compared++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] %0t: got %h expected %h", $time, s, e);
        end
    endtask
    // one apb transfer; request held until pready is seen high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // one serial frame: load, start, poll busy, fetch the response
    task frame(input logic [15:0] w, output logic [15:0] r);
        logic [31:0] q;
        logic        e;
        apb(1'b1, `UFS_APB_WDATA, {16'h0000, w}, q, e);
        apb(1'b1, `UFS_APB_CTRL, 32'h0000_0001, q, e);
        q = 32'h0000_0001;
        while (q[0] !== 1'b0) apb(1'b0, `UFS_APB_STAT, 32'h0000_0000, q, e);
        apb(1'b0, `UFS_APB_RDATA, 32'h0000_0000, q, e);
        r = q[15:0];
    endtask
    task dwr(input logic [5:0] a, input logic [7:0] d, output logic [15:0] r);
        frame({1'b0, a, 1'b0, d}, r);
    endtask
    task drd(input logic [5:0] a, output logic [15:0] r);
        frame({1'b1, a, 9'h000}, r);
    endtask
    // the next frame's status reports the state set by the previous one
    task t_modes;
        logic [15:0] r;
        dwr(`UFS_A_MODE, 8'h01, r);
        dwr(`UFS_A_MODE, 8'h00, r);
        chk(16'(r[10:9]), 16'(UFS_SLEEP));
        chk(16'(st), 16'(UFS_LISTEN));
        dwr(`UFS_A_MODE, 8'h02, r);
        chk(16'(st), 16'(UFS_STANDBY));
        dwr(`UFS_A_MODE, 8'h00, r);
        chk(16'(r[10:9]), 16'(UFS_STANDBY));
        dwr(`UFS_A_MODE, 8'h08, r);
        chk(16'(st), 16'(UFS_BURST));
        flt <= 5'h01;
        repeat (4) @(posedge clk);
        chk(16'(st), 16'(UFS_LISTEN));
        dwr(`UFS_A_MODE, 8'h05, r);
        flt <= 5'h00;
        dwr(`UFS_A_MODE, 8'h04, r);
        chk(16'(st), 16'(UFS_SLEEP));
        repeat (WAIT_T) @(posedge clk);
        chk(16'(st), 16'(UFS_LISTEN));
        dwr(`UFS_A_MODE, 8'h05, r);
        flt <= 5'h10;
        dwr(`UFS_A_MODE, 8'h04, r);
        chk(16'(st), 16'(UFS_LISTEN));
    endtask
    // filter fields, reset values, echo and readback order
    task t_filter;
        logic [15:0] r;
        drd(`UFS_A_DRV_REG, r);
        chk(r[7:0], `UFS_RST_DRV_REG);
        drd(`UFS_A_BPF_A, r);
        chk({r[15], r[7:0]}, 9'h000);
        dwr(`UFS_A_BPF_B, 8'h23, r);
        chk(r[7:0], {2'b00, `UFS_A_BPF_B});
        dwr(`UFS_A_BPF_A, 8'h9a, r);
        chk(16'({byp, fac, qs, cf}), 16'({2'b00, 2'h2, 6'h1d}));
        for (int i = 0; i < 4; i++) begin
            dwr(`UFS_A_BPF_A, 8'h45 + 8'(i * 16), r);
            chk(16'({byp, cor, fac}), 16'({1'b1, 2'(i), 1'b1}));
        end
        drd(`UFS_A_BPF_A, r);
        chk(r[7:0], 8'h75);
    endtask
    // fault inputs mirrored into the response status field
    task t_status;
        logic [15:0] r;
        flt <= 5'b10110;
        drd(`UFS_A_DEVID, r);
        chk(r[14:9], 6'b101100);
        flt <= 5'b01000;
        drd(`UFS_A_DEVID, r);
        chk(r[14:9], 6'b010000);
    endtask
    // unmapped apb word is refused; read-only device word keeps its value
    task t_refused;
        logic [31:0] q;
        logic        e;
        logic [15:0] r;
        apb(1'b0, 12'h010, 32'h0000_0000, q, e);
        chk({e, q[14:0]}, 16'h8000);
        dwr(`UFS_A_DEVID, 8'hff, r);
        drd(`UFS_A_DEVID, r);
        chk(r[7:0], `UFS_DEVID_VAL);
    endtask
    task test_done;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_modes();
        t_filter();
        t_status();
        t_refused();
        test_done();
    end
endmodule
